// File: logic/nvmac_pkg.sv
// nvmac_pkg: constants and carriers for the nonvolatile data area controller.
// assumes an 8-bit special-register port with byte addresses.
package nvmac_pkg;

  // register addresses
  localparam logic [7:0] NVM_COMMAND_ADDR     = 8'h95;
  localparam logic [7:0] NVM_AREA_SELECT_ADDR = 8'h96;
  localparam logic [7:0] NVM_COMMAND_RESET    = 8'h00;
  localparam logic [7:0] NVM_AREA_RESET       = 8'h00;

  // command register field positions
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT  = 1;
  localparam int CMD_ERASE_BIT = 2;
  localparam int CMD_DONE_BIT  = 3;
  localparam int CMD_LOW_BITS  = 4;

  // geometry
  localparam int AREA_BYTES    = 128;
  localparam int AREA_COUNT    = 16;
  localparam int AREA_SEL_W    = 4;
  localparam int BYTE_IDX_W    = 7;
  localparam int REGION_BYTES  = 2048;
  localparam int REGION_ADDR_W = 11;
  localparam int FLASH_KB      = 32;
  localparam int FLASH_KB_WITH_REGION = 30;
  localparam int XRAM_ADDR_W   = 16;
  localparam logic [15:0] XRAM_BUF_BASE = 16'hFF80;
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;

  // read time figure: 0.53 ms at 256 kHz, i.e. 135 system cycles after rounding down.
  // the delay scales with the clock, so it is held as a cycle count.
  localparam int READ_TIME_NS_AT_256K = 530000;
  localparam int REF_CLK_HZ           = 256000;
  localparam int READ_CYCLES =
    (READ_TIME_NS_AT_256K / 1000) * (REF_CLK_HZ / 1000) / 1000;
  localparam int CNT_W = 16;

  // code option bit positions
  localparam int OPT_REGION_EN_BIT   = 3;
  localparam int OPT_RESET_LATCH_BIT = 4;

  typedef enum logic [3:0] {
    NVMAC_IDLE  = 4'b0001,
    NVMAC_WAIT  = 4'b0010,
    NVMAC_MOVE  = 4'b0100,
    NVMAC_DONE  = 4'b1000
  } nvmac_state_t;

  typedef enum logic [1:0] {
    NVMAC_OP_READ  = 2'h0,
    NVMAC_OP_WRITE = 2'h1,
    NVMAC_OP_ERASE = 2'h2
  } nvmac_op_t;

  // buffer window access toward external RAM
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } nvmac_xram_req_t;

  // region storage access
  typedef struct packed {
    logic        we;
    logic [10:0] addr;
    logic [7:0]  wdata;
  } nvmac_mem_req_t;

endpackage : nvmac_pkg

// File: logic/nvmac_store.sv
// nvmac_store: 2K-byte nonvolatile region array, one byte per cycle.
// assumes retention is modelled by not being cleared on reset.
`timescale 1ns/1ps
module nvmac_store #(
  parameter int BYTES = nvmac_pkg::REGION_BYTES
) (
  input  wire logic                    clk_sys_i,
  input  wire nvmac_pkg::nvmac_mem_req_t mem_i,
  output logic [7:0]                   rdata_o
);

  logic [7:0] cells [BYTES];

  // contents survive reset like flash cells
  always_ff @(posedge clk_sys_i) begin
    if (mem_i.we) begin
      cells[mem_i.addr] <= mem_i.wdata;
    end
    rdata_o <= cells[mem_i.addr];
  end

endmodule : nvmac_store

// File: logic/nvmac_timer.sv
// nvmac_timer: counts system cycles for one command's busy time.
// assumes start is a one-cycle pulse; done pulses once when the count ends.
`timescale 1ns/1ps
module nvmac_timer #(
  parameter int CYCLES = nvmac_pkg::READ_CYCLES
) (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic start_i,
  output logic      done_o
);

  logic [nvmac_pkg::CNT_W-1:0] count;
  logic                        running;

  // fixed cycle count: time in ms scales inversely with the clock rate
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      count   <= '0;
      running <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        count   <= '0;
        running <= 1'b1;
      end else if (running) begin
        if (count == nvmac_pkg::CNT_W'(CYCLES - 1)) begin
          running <= 1'b0;
          done_o  <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule : nvmac_timer

// File: logic/nvmac_ctrl.sv
// nvmac_ctrl: data area controller top, command and area select registers,
// sequencer that moves one 128-byte area between region and buffer window.
// assumes the cpu special-register port (8-bit, one-cycle strobes) and a
// single-cycle external RAM port for the buffer window.
//
// Functional notes
// - 2K nonvolatile region in top flash
// - command write launches operation at once
// - bit 3 done flag, hardware sets, firmware clears
// - bit 2 erases selected 128-byte area
// - bit 0 writes, bit 1 reads area
// - 4-bit area select chooses area 0..15
// - top 128 xram bytes map area bytes
// - read time scales inversely with clock
// - option bit 3 low enables region, flash 30KB
// - option bit 4 latches options on reset
// - bits 7..4 read zero, reset zero
`timescale 1ns/1ps
module nvmac_ctrl #(
  parameter int BUSY_CYCLES = nvmac_pkg::READ_CYCLES
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        sys_rst_i,
  input  wire logic [7:0]                  sfr_addr_i,
  input  wire logic                        sfr_wr_i,
  input  wire logic                        sfr_rd_i,
  input  wire logic [7:0]                  sfr_wdata_i,
  output logic [7:0]                       sfr_rdata_o,
  input  wire logic [7:0]                  code_option_i,
  output nvmac_pkg::nvmac_xram_req_t       xram_o,
  input  wire logic [7:0]                  xram_rdata_i,
  output logic                             busy_o,
  output logic                             region_enabled_o,
  output logic [5:0]                       flash_kb_o
);

  // registers and sequencer state
  logic [3:0]               cmd_bits;
  logic [3:0]               area_select;
  logic [7:0]               opt_latched;
  logic                     opt_valid;
  nvmac_pkg::nvmac_state_t  state;
  nvmac_pkg::nvmac_op_t     op;
  logic [3:0]               op_area;
  logic [7:0]               idx;
  logic                     phase;
  logic                     timer_start;
  logic                     timer_done;
  logic [7:0]               mem_rdata;
  nvmac_pkg::nvmac_mem_req_t mem_req;
  logic                     cmd_wr;
  logic                     launch;
  logic                     region_en;
  logic                     next_region_en;

  // option pin synchroniser stages and the filtered option byte
  logic [7:0]               opt_sync1;
  logic [7:0]               opt_sync2;
  logic [7:0]               opt_sync3;
  logic [7:0]               opt_live;

  // address of byte n of area a in the region
  function automatic logic [10:0] region_addr(input logic [3:0] a, input logic [6:0] n);
    region_addr = {a, n};
  endfunction : region_addr

  // register decode, shared by the write enables and the read mux
  function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] target);
    sfr_hit = (addr == target);
  endfunction : sfr_hit

  // option pins sit outside this clock domain: three stages, and a bit
  // only moves once stages two and three agree, so a glitch never lands
  always_ff @(posedge clk_sys_i) begin
    opt_sync1 <= code_option_i;
    opt_sync2 <= opt_sync1;
    opt_sync3 <= opt_sync2;
  end

  // filtered option byte; left unreset so the pins settle during reset
  // and the latch below catches a clean value at the first edge after it
  always_ff @(posedge clk_sys_i) begin
    for (int b = 0; b < 8; b++) begin
      if (opt_sync2[b] == opt_sync3[b]) begin
        opt_live[b] <= opt_sync3[b];
      end
    end
  end

  // code option latch: with bit 4 set the options are caught once after
  // reset release and kept; otherwise they follow the option pins live
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      opt_valid   <= 1'b0;
      opt_latched <= 8'hFF;
    end else if (!opt_valid) begin
      opt_valid   <= 1'b1;
      opt_latched <= opt_live;
    end
  end

  // enable bit is active low; the latched copy wins once bit 4 was caught
  always_comb begin
    if (opt_valid && opt_latched[nvmac_pkg::OPT_RESET_LATCH_BIT]) begin
      next_region_en = !opt_latched[nvmac_pkg::OPT_REGION_EN_BIT];
    end else begin
      next_region_en = !opt_live[nvmac_pkg::OPT_REGION_EN_BIT];
    end
  end

  // enable and flash size leave from flops; launch uses the same flop,
  // so the enable output and what really starts never disagree
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      region_en  <= 1'b0;
      flash_kb_o <= 6'(nvmac_pkg::FLASH_KB);
    end else begin
      region_en  <= next_region_en;
      flash_kb_o <= next_region_en ? 6'(nvmac_pkg::FLASH_KB_WITH_REGION)
                                   : 6'(nvmac_pkg::FLASH_KB);
    end
  end

  assign region_enabled_o = region_en;

  assign cmd_wr = sfr_wr_i && sfr_hit(sfr_addr_i, nvmac_pkg::NVM_COMMAND_ADDR);
  // any set bit of 2..0 starts work; launched while idle only, since
  // firmware is expected to wait for finish before the next one
  assign launch = cmd_wr && region_en && (state == nvmac_pkg::NVMAC_IDLE) &&
                  (|sfr_wdata_i[nvmac_pkg::CMD_ERASE_BIT:0]);

  // area select register, low nibble only; the upper nibble is reserved
  // and never stored, so it cannot leak into the region address
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      area_select <= nvmac_pkg::NVM_AREA_RESET[3:0];
    end else if (sfr_wr_i && sfr_hit(sfr_addr_i, nvmac_pkg::NVM_AREA_SELECT_ADDR)) begin
      area_select <= sfr_wdata_i[3:0];
    end
  end

  // command register: command bits clear as the operation ends; the done
  // flag is set by hardware and cleared by a command write with bit 3 zero or by a launching write.
  // set wins over a clear in the same cycle.
  // a write while busy still lands in bits 2..0 but launches nothing;
  // the sequencer clears them when the running operation ends.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cmd_bits <= nvmac_pkg::NVM_COMMAND_RESET[3:0];
    end else begin
      if (cmd_wr) begin
        cmd_bits[2:0] <= sfr_wdata_i[2:0];
        if (!sfr_wdata_i[nvmac_pkg::CMD_DONE_BIT]) begin
          cmd_bits[nvmac_pkg::CMD_DONE_BIT] <= 1'b0;
        end
        if (launch) begin
          cmd_bits[nvmac_pkg::CMD_DONE_BIT] <= 1'b0;
        end
      end
      if (state == nvmac_pkg::NVMAC_DONE) begin
        cmd_bits[2:0] <= 3'h0;
        cmd_bits[nvmac_pkg::CMD_DONE_BIT] <= 1'b1;
      end
    end
  end

  // register read mux, reserved upper bits read zero; registered, so the
  // cpu sees data one cycle after its strobe and zero at any other time
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i && sfr_hit(sfr_addr_i, nvmac_pkg::NVM_COMMAND_ADDR)) begin
      sfr_rdata_o <= {4'h0, cmd_bits};
    end else if (sfr_rd_i && sfr_hit(sfr_addr_i, nvmac_pkg::NVM_AREA_SELECT_ADDR)) begin
      sfr_rdata_o <= {4'h0, area_select};
    end else begin
      sfr_rdata_o <= 8'h00;
    end
  end

  // sequencer: wait out the busy time, then move 128 bytes one by one.
  // erase has priority over read, read over write if several bits are set.
  // write and erase reuse the read busy time: only the read figure is
  // known, so the other two are assumed no slower at the same clock.
  // limitation: the byte move adds 256 cycles on top of the busy count.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state   <= nvmac_pkg::NVMAC_IDLE;
      op      <= nvmac_pkg::NVMAC_OP_READ;
      op_area <= 4'h0;
      idx     <= 8'h00;
      phase   <= 1'b0;
    end else begin
      case (state)
        nvmac_pkg::NVMAC_IDLE: begin
          if (launch) begin
            op_area <= area_select;
            if (sfr_wdata_i[nvmac_pkg::CMD_ERASE_BIT]) begin
              op <= nvmac_pkg::NVMAC_OP_ERASE;
            end else if (sfr_wdata_i[nvmac_pkg::CMD_READ_BIT]) begin
              op <= nvmac_pkg::NVMAC_OP_READ;
            end else begin
              op <= nvmac_pkg::NVMAC_OP_WRITE;
            end
            state <= nvmac_pkg::NVMAC_WAIT;
          end
        end
        nvmac_pkg::NVMAC_WAIT: begin
          if (timer_done) begin
            idx   <= 8'h00;
            phase <= 1'b0;
            state <= nvmac_pkg::NVMAC_MOVE;
          end
        end
        nvmac_pkg::NVMAC_MOVE: begin
          // phase 0 issues a read, phase 1 writes the fetched byte
          phase <= ~phase;
          if (phase) begin
            if (idx == 8'(nvmac_pkg::AREA_BYTES - 1)) begin
              state <= nvmac_pkg::NVMAC_DONE;
            end
            idx <= idx + 8'h01;
          end
        end
        nvmac_pkg::NVMAC_DONE: begin
          state <= nvmac_pkg::NVMAC_IDLE;
        end
        default: begin
          state <= nvmac_pkg::NVMAC_IDLE;
        end
      endcase
    end
  end

  // timer shares the launch pulse, so busy and timing begin together
  assign timer_start = launch;
  assign busy_o = (state != nvmac_pkg::NVMAC_IDLE);

  // region port: write on phase 1 for program and erase
  always_comb begin
    mem_req.addr  = region_addr(op_area, idx[6:0]);
    mem_req.we    = (state == nvmac_pkg::NVMAC_MOVE) && phase &&
                    (op != nvmac_pkg::NVMAC_OP_READ);
    mem_req.wdata = (op == nvmac_pkg::NVMAC_OP_ERASE) ? nvmac_pkg::ERASED_BYTE
                                                      : xram_rdata_i;
  end

  // buffer window port: byte n lives at base + n
  always_comb begin
    xram_o.addr  = nvmac_pkg::XRAM_BUF_BASE + {9'h000, idx[6:0]};
    xram_o.req   = (state == nvmac_pkg::NVMAC_MOVE) &&
                   ((op == nvmac_pkg::NVMAC_OP_WRITE && !phase) ||
                    (op == nvmac_pkg::NVMAC_OP_READ && phase));
    xram_o.we    = (state == nvmac_pkg::NVMAC_MOVE) && phase &&
                   (op == nvmac_pkg::NVMAC_OP_READ);
    xram_o.wdata = mem_rdata;
  end

  // busy timer: one cycle count for every command
  nvmac_timer #(
    .CYCLES (BUSY_CYCLES)
  ) u_timer (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (timer_start),
    .done_o    (timer_done)
  );

  // region array, one byte per cycle; contents are kept across reset
  nvmac_store #(
    .BYTES (nvmac_pkg::REGION_BYTES)
  ) u_store (
    .clk_sys_i (clk_sys_i),
    .mem_i     (mem_req),
    .rdata_o   (mem_rdata)
  );

endmodule : nvmac_ctrl

// File: tb/nvmac_ctrl_asserts.sv
// nvmac_ctrl_asserts: port-level timing checks of the data area controller.
// assumes a bind onto nvmac_ctrl and sees only its ports.
`timescale 1ns/1ps
module nvmac_ctrl_asserts (
  input wire logic                       clk_sys_i,
  input wire logic                       sys_rst_i,
  input wire logic [7:0]                 sfr_addr_i,
  input wire logic                       sfr_wr_i,
  input wire logic                       sfr_rd_i,
  input wire logic [7:0]                 sfr_wdata_i,
  input wire logic [7:0]                 sfr_rdata_o,
  input wire nvmac_pkg::nvmac_xram_req_t xram_o,
  input wire logic                       busy_o,
  input wire logic                       region_enabled_o,
  input wire logic [5:0]                 flash_kb_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  // an idle, enabled command write starts work on the very next cycle
  chk_launch_busy: assert property (sfr_wr_i && sfr_addr_i == 8'h95 && sfr_wdata_i[2:0] != 3'h0
    && !busy_o && region_enabled_o |=> busy_o) else $error("command did not start");
  chk_flash_on: assert property (region_enabled_o |-> flash_kb_o == 6'h1E)
    else $error("flash size wrong with region on");
  chk_flash_off: assert property (!region_enabled_o |-> flash_kb_o == 6'h20)
    else $error("flash size wrong with region off");
  // a whole area move needs far more than eight cycles, but must end
  chk_busy_min: assert property ($rose(busy_o) |-> busy_o[*8])
    else $error("operation ended too soon");
  chk_busy_bound: assert property ($rose(busy_o) |-> ##[1:600] !busy_o)
    else $error("operation never ended");
  chk_unmapped_zero: assert property (sfr_rd_i && sfr_addr_i != 8'h95 && sfr_addr_i != 8'h96
    |=> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
  chk_reserved_zero: assert property (sfr_rd_i |=> sfr_rdata_o[7:4] == 4'h0)
    else $error("reserved bits not zero");
  chk_xram_window: assert property (xram_o.req |-> xram_o.addr[15:7] == 9'h1FF)
    else $error("buffer access outside window");
  chk_xram_idle: assert property (!busy_o |-> !xram_o.req)
    else $error("buffer access while idle");
endmodule : nvmac_ctrl_asserts

bind nvmac_ctrl nvmac_ctrl_asserts u_chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
  .sfr_rdata_o(sfr_rdata_o), .xram_o(xram_o), .busy_o(busy_o),
  .region_enabled_o(region_enabled_o), .flash_kb_o(flash_kb_o));

// File: tb/test_nvmac_ctrl.sv
// test_nvmac_ctrl: self-checking bench with a region model and buffer window.
// assumes nvmac_ctrl with a short busy count and the bench serving xram.
`timescale 1ns/1ps
module test_nvmac_ctrl;
  logic                       clk_sys_i, sys_rst_i, sfr_wr_i, sfr_rd_i, busy_o, region_enabled_o;
  logic [7:0]                 sfr_addr_i, sfr_wdata_i, sfr_rdata_o, code_option_i, xram_rdata_i;
  logic [5:0]                 flash_kb_o;
  logic [6:0]                 rd_idx;
  logic                       rd_pend = 1'b0;
  logic [7:0]                 v;
  logic [7:0]                 xb [128];
  logic [7:0]                 mdl [2048];
  nvmac_pkg::nvmac_xram_req_t xram_o;
  integer                     mismatches = 0, num_checks = 0, seed = 75818, area;

  nvmac_ctrl #(.BUSY_CYCLES(4)) DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .code_option_i(code_option_i), .xram_o(xram_o),
    .xram_rdata_i(xram_rdata_i), .busy_o(busy_o), .region_enabled_o(region_enabled_o),
    .flash_kb_o(flash_kb_o));

  // 25 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // buffer window: writes land at the edge, read data one cycle later
  always @(posedge clk_sys_i) begin
    rd_pend <= xram_o.req && !xram_o.we;
    rd_idx <= xram_o.addr[6:0];
    if (xram_o.req && xram_o.we) xb[xram_o.addr[6:0]] <= xram_o.wdata;
  end
  // unrequested cycles carry noise so a stale byte never passes
  always @(negedge clk_sys_i) xram_rdata_i <= rd_pend ? xb[rd_idx] : 8'($random(seed));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_sys_i);
    sfr_wr_i = 1'b0;
    // one idle cycle: the next call never raises the strobe just lowered
    @(negedge clk_sys_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge clk_sys_i);
    sfr_rd_i = 1'b0;
    d = sfr_rdata_o;
    @(negedge clk_sys_i);
  endtask : rd

  // one command: launch, poll for finish, update model, clear done
  task automatic run_cmd(input logic [7:0] c);
    logic [7:0] r;
    int n;
    for (n = 0; n < 128; n++) xb[n] = 8'($random(seed));
    wr(8'h95, c);
    check("busy_o", 8'h01, {7'h0, busy_o});
    rd(8'h95, r);
    check("command while busy", c & 8'h07, r);
    n = 0;
    while (r[3] !== 1'b1 && n < 1000) begin
      rd(8'h95, r);
      n++;
    end
    check("command at finish", 8'h08, r);
    for (n = 0; n < 128; n++) begin
      if (c[2]) mdl[area * 128 + n] = 8'hFF;
      if (c[0]) mdl[area * 128 + n] = xb[n];
      if (c[1]) check("buffer byte", mdl[area * 128 + n], xb[n]);
    end
    wr(8'h95, 8'h00);
    rd(8'h95, r);
    check("command after clear", 8'h00, r);
  endtask : run_cmd

  task automatic give_verdict();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // a hang counts against the run
  initial begin
    #(40 * 30000);
    mismatches++;
    give_verdict();
  end

  // main sequence
  initial begin
    sys_rst_i = 1'b1;
    {sfr_wr_i, sfr_rd_i, sfr_addr_i, sfr_wdata_i, code_option_i} = '0;
    repeat (4) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rd(8'h95, v);
    check("command reset", 8'h00, v);
    rd(8'h96, v);
    check("area reset", 8'h00, v);
    rd(8'h97, v);
    check("unmapped read", 8'h00, v);
    wr(8'h96, 8'hFF);
    rd(8'h96, v);
    check("area select", 8'h0F, v);
    check("flash_kb_o", 8'h1E, {2'b0, flash_kb_o});
    // top, bottom and a random area: erase, read, write, read back
    for (int k = 0; k < 3; k++) begin
      area = (k == 0) ? 15 : (k == 1) ? 0 : ($random(seed) & 15);
      wr(8'h96, 8'(area));
      run_cmd(8'h04);
      run_cmd(8'h02);
      run_cmd(8'h01);
      run_cmd(8'h02);
    end
    // region disabled by option: nothing may start
    // option pins pass a synchroniser and a flop: allow six cycles
    code_option_i = 8'h08;
    repeat (6) @(negedge clk_sys_i);
    check("region_enabled_o", 8'h00, {7'h0, region_enabled_o});
    check("flash_kb_o", 8'h20, {2'b0, flash_kb_o});
    wr(8'h95, 8'h02);
    repeat (3) @(negedge clk_sys_i);
    check("busy_o disabled", 8'h00, {7'h0, busy_o});
    wr(8'h95, 8'h00);
    // latch option: caught at a mid-run reset, later pin changes ignored
    code_option_i = 8'h10;
    repeat (6) @(negedge clk_sys_i);
    check("region_enabled_o live", 8'h01, {7'h0, region_enabled_o});
    wr(8'h96, 8'h05);
    sys_rst_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rd(8'h96, v);
    check("area after reset", 8'h00, v);
    code_option_i = 8'h18;
    repeat (6) @(negedge clk_sys_i);
    check("region_enabled_o latched", 8'h01, {7'h0, region_enabled_o});
    check("flash_kb_o latched", 8'h1E, {2'b0, flash_kb_o});
    // region contents survive the reset; area select is back at zero
    area = 0;
    run_cmd(8'h02);
    give_verdict();
  end
endmodule : test_nvmac_ctrl
